/* rms_host_model.sv */
// Host controller model: register bus master and power-down pin
`timescale 1ns/1ps
module rms_host_model (
  input wire logic clk,
  output logic [5:0] addr,
  output logic rd_en,
  output logic wr_en,
  output logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic wait_req,
  output logic pdn
);
  int tmo = 0;
  // ==========================================
  // Idle bus, pin held low outside shutdown
  initial begin
    addr = 6'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 32'h00000000;
    pdn = 1'b0;
  end
  // One transfer held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h000000, d};
    rd_en <= !w;
    wr_en <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 200);
    q = rdata[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (n >= 200) tmo++;
  endtask
  // Shutdown pin level
  task automatic set_pdn(input logic v);
    @(posedge clk);
    pdn <= v;
  endtask
  // Status reads after power-on, clearing the crystal buffer override
  task automatic por_clear(output logic [7:0] q);
    xfer(1'b1, 6'h08, 8'h00, q);
    xfer(1'b0, 6'h03, 8'h00, q);
    xfer(1'b0, 6'h04, 8'h00, q);
  endtask
endmodule

/* rms_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef RMS_PARAMS_SVH
`define RMS_PARAMS_SVH

// ==========================================================
// Register word addresses (consecutive, one per 32-bit word)
`define RMS_ADDR_CHIP_COND 6'h02
`define RMS_ADDR_IRQ_STAT1 6'h03
`define RMS_ADDR_IRQ_STAT2 6'h04
`define RMS_ADDR_IRQ_EN1 6'h05
`define RMS_ADDR_IRQ_EN2 6'h06
`define RMS_ADDR_MODE_CTRL 6'h07
`define RMS_ADDR_XTAL_CTRL 6'h08
`define RMS_ADDR_EVENT_SET 6'h09
`define RMS_ADDR_POWER_STAT 6'h0A

// ==========================================================
// Mode control fields
`define RMS_MC_XTON 0
`define RMS_MC_PLLON 1
`define RMS_MC_RXON 2
`define RMS_MC_TXON 3
`define RMS_MC_SKIPCAL 4
`define RMS_MC_LBD 5
`define RMS_MC_WUT 6
`define RMS_MC_SWRST 7
`define RMS_MODE_RESET 8'h01
`define RMS_IRQ_EN1_RESET 8'h00
`define RMS_IRQ_EN2_RESET 8'h01
`define RMS_XTAL_BUFOVR 1

// ==========================================================
// Chip power state encoding
`define RMS_CPS_IDLE 2'h0
`define RMS_CPS_RX 2'h1
`define RMS_CPS_TX 2'h2
`define RMS_CPS_SHDN 2'h3

// ==========================================================
// Timing at 100 MHz
`define RMS_CLK_MHZ 100
`define RMS_POR_US 16000
`define RMS_LONG_US 600
`define RMS_PLL_US 200
`define RMS_POR_CYC (`RMS_POR_US * `RMS_CLK_MHZ)
`define RMS_XTAL_CYC (`RMS_LONG_US * `RMS_CLK_MHZ)
`define RMS_PLL_CYC (`RMS_PLL_US * `RMS_CLK_MHZ)
`define RMS_CAL_CYC 16'h0FA0

`endif

/* rms_pkg.sv */
// Types of the radio mode sequencer
package rms_pkg;
  typedef enum logic [3:0] {
    ST_SHDN, ST_POR, ST_IDLE, ST_REG, ST_XTAL, ST_PLL, ST_CAL, ST_SETTLE,
    ST_RAMP, ST_TX, ST_RXEN, ST_RX
  } rms_state_e;
endpackage

/* rms_radio_mode_sequencer.sv */
// Operating-mode controller with Avalon-MM register slave
//
// Contract
// - Shutdown, idle, transmit, receive top states
// - Power-down pin forces shutdown, clears registers
// - Power-on reset starts after pin falls
// - Resets and shutdown exit enter ready
// - Zero mode value selects standby
// - Registers stay accessible in standby
// - Wake-timer bit selects sleep
// - Battery-detect bit enables detector, sensor
// - Crystal-on bit selects ready
// - Synth-on selects tune, crystal auto
// - Transmit bit starts sequencer from idle
// - Regulators, crystal, PLL, cal, settle, ramp
// - Skip-calibration bit skips VCO calibration
// - Satisfied steps omitted, recalibrate each PLL
// - Receive runs same steps then RX path
// - Modem receive functions enabled once receiving
// - Latencies 16ms, 800us, 200us
// - Low-power regulator only standby and sleep
// - Status register layout with power state
// - Status read clears enabled flags, releases
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "rms_params.svh"

module rms_radio_mode_sequencer (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic POWER_DOWN_PIN,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic INTERRUPT_REQUEST_N,
  output logic MAIN_REGULATOR_EN,
  output logic LOW_POWER_REGULATOR_EN,
  output logic XTAL_EN,
  output logic PLL_EN,
  output logic VCO_CAL_EN,
  output logic PA_EN,
  output logic RX_PATH_EN,
  output logic MODEM_RX_EN,
  output logic WAKE_TIMER_EN,
  output logic BATT_DETECT_EN
);

  typedef struct packed {
    logic [1:0] pin_sync;
    logic pin_q;
    rms_pkg::rms_state_e state;
    logic [23:0] timer;
    logic target_tx;
    logic [7:0] mode;
    logic [7:0] xtal_ctrl;
    logic [7:0] irq_st1;
    logic [7:0] irq_st2;
    logic [7:0] irq_en1;
    logic [7:0] irq_en2;
    logic [1:0] cps;
    logic [7:0] cond_hi;
    logic [31:0] rdata;
    logic wait_n;
    logic irq_n;
    logic [9:0] pwr;
  } rms_regs_s;

  rms_regs_s r_ff;
  rms_regs_s nxt_r;

  logic pin_hi;
  logic acc;
  logic want_tx;
  logic want_rx;
  logic idle_xtal;
  logic idle_pll;
  logic [7:0] sel_rd;

  // ==========================================================
  // Request decode and idle sub-mode priority
  assign pin_hi = r_ff.pin_sync[1];
  assign acc = (AVS_READ | AVS_WRITE) & ~r_ff.wait_n;
  assign want_tx = r_ff.mode[`RMS_MC_TXON] & ~r_ff.mode[`RMS_MC_RXON];
  assign want_rx = r_ff.mode[`RMS_MC_RXON];
  assign idle_pll = r_ff.mode[`RMS_MC_PLLON];
  assign idle_xtal = r_ff.mode[`RMS_MC_XTON] | idle_pll;

  // Read data mux
  always_comb begin
    case (AVS_ADDRESS)
      `RMS_ADDR_CHIP_COND: sel_rd = {r_ff.cond_hi[7:3], 1'b0, r_ff.cps};
      `RMS_ADDR_IRQ_STAT1: sel_rd = r_ff.irq_st1;
      `RMS_ADDR_IRQ_STAT2: sel_rd = r_ff.irq_st2;
      `RMS_ADDR_IRQ_EN1: sel_rd = r_ff.irq_en1;
      `RMS_ADDR_IRQ_EN2: sel_rd = r_ff.irq_en2;
      `RMS_ADDR_MODE_CTRL: sel_rd = r_ff.mode;
      `RMS_ADDR_XTAL_CTRL: sel_rd = r_ff.xtal_ctrl;
      `RMS_ADDR_POWER_STAT: sel_rd = r_ff.pwr[7:0];
      default: sel_rd = 8'h00;
    endcase
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt_r = r_ff;
    nxt_r.pin_sync = {r_ff.pin_sync[0], POWER_DOWN_PIN};
    nxt_r.pin_q = pin_hi;
    nxt_r.wait_n = 1'b0;
    if (r_ff.timer != 24'h000000) begin
      nxt_r.timer = r_ff.timer - 24'h000001;
    end

    // Bus slave: one wait cycle, then the answer
    if (acc && r_ff.state != rms_rms_dummy()) begin
      nxt_r.wait_n = 1'b1;
    end
    if (acc) begin
      nxt_r.wait_n = 1'b1;
      nxt_r.rdata = {24'h000000, sel_rd};
    end
    if (r_ff.wait_n && AVS_READ) begin
      // Reading a status register clears enabled flags
      if (AVS_ADDRESS == `RMS_ADDR_IRQ_STAT1) begin
        nxt_r.irq_st1 = r_ff.irq_st1 & ~r_ff.irq_en1;
      end
      if (AVS_ADDRESS == `RMS_ADDR_IRQ_STAT2) begin
        nxt_r.irq_st2 = r_ff.irq_st2 & ~r_ff.irq_en2;
      end
    end
    if (r_ff.wait_n && AVS_WRITE) begin
      // Registers writable in every powered state
      case (AVS_ADDRESS)
        `RMS_ADDR_MODE_CTRL: nxt_r.mode = AVS_WRITEDATA[7:0];
        `RMS_ADDR_IRQ_EN1: nxt_r.irq_en1 = AVS_WRITEDATA[7:0];
        `RMS_ADDR_IRQ_EN2: nxt_r.irq_en2 = AVS_WRITEDATA[7:0];
        `RMS_ADDR_XTAL_CTRL: nxt_r.xtal_ctrl = AVS_WRITEDATA[7:0];
        `RMS_ADDR_EVENT_SET: begin
          nxt_r.irq_st1 = r_ff.irq_st1 | AVS_WRITEDATA[7:0];
          nxt_r.cond_hi = AVS_WRITEDATA[15:8];
        end
        default: ;
      endcase
    end

    // Sequencer
    case (r_ff.state)
      rms_pkg::ST_SHDN: begin
        nxt_r.cps = `RMS_CPS_SHDN;
        if (!pin_hi && r_ff.pin_q) begin
          nxt_r.state = rms_pkg::ST_POR;
          nxt_r.timer = 24'(`RMS_POR_CYC);
        end
      end
      rms_pkg::ST_POR: begin
        if (r_ff.timer == 24'h000000) begin
          nxt_r.state = rms_pkg::ST_IDLE;
          nxt_r.mode = `RMS_MODE_RESET;
          nxt_r.irq_st2 = 8'h01;
          nxt_r.cps = `RMS_CPS_IDLE;
        end
      end
      rms_pkg::ST_IDLE: begin
        if (r_ff.mode[`RMS_MC_SWRST]) begin
          nxt_r.mode = `RMS_MODE_RESET;
          nxt_r.irq_en1 = `RMS_IRQ_EN1_RESET;
          nxt_r.irq_en2 = `RMS_IRQ_EN2_RESET;
          nxt_r.xtal_ctrl = 8'h00;
        end else if (want_tx || want_rx) begin
          nxt_r.target_tx = want_tx;
          if (idle_pll) begin
            nxt_r.state = rms_pkg::ST_PLL;
            nxt_r.timer = 24'h000000;
          end else if (idle_xtal) begin
            nxt_r.state = rms_pkg::ST_PLL;
          end else begin
            nxt_r.state = rms_pkg::ST_REG;
          end
        end
      end
      rms_pkg::ST_REG: begin
        nxt_r.state = rms_pkg::ST_XTAL;
        nxt_r.timer = 24'(`RMS_XTAL_CYC);
      end
      rms_pkg::ST_XTAL: begin
        if (r_ff.timer == 24'h000000) begin
          nxt_r.state = rms_pkg::ST_PLL;
        end
      end
      rms_pkg::ST_PLL: begin
        if (r_ff.mode[`RMS_MC_SKIPCAL]) begin
          nxt_r.state = rms_pkg::ST_SETTLE;
          nxt_r.timer = 24'(`RMS_PLL_CYC);
        end else begin
          nxt_r.state = rms_pkg::ST_CAL;
          nxt_r.timer = 24'(`RMS_CAL_CYC);
        end
      end
      rms_pkg::ST_CAL: begin
        if (r_ff.timer == 24'h000000) begin
          nxt_r.state = rms_pkg::ST_SETTLE;
          nxt_r.timer = 24'(`RMS_PLL_CYC - `RMS_CAL_CYC - 3);
        end
      end
      rms_pkg::ST_SETTLE: begin
        if (r_ff.timer == 24'h000000) begin
          nxt_r.state = r_ff.target_tx ? rms_pkg::ST_RAMP : rms_pkg::ST_RXEN;
        end
      end
      rms_pkg::ST_RAMP: begin
        nxt_r.state = rms_pkg::ST_TX;
        nxt_r.cps = `RMS_CPS_TX;
      end
      rms_pkg::ST_RXEN: begin
        nxt_r.state = rms_pkg::ST_RX;
        nxt_r.cps = `RMS_CPS_RX;
      end
      rms_pkg::ST_TX, rms_pkg::ST_RX: begin
        // Leave or swap direction; swap re-runs PLL steps
        if (!want_tx && !want_rx) begin
          nxt_r.state = rms_pkg::ST_IDLE;
          nxt_r.cps = `RMS_CPS_IDLE;
        end else if (want_tx != r_ff.target_tx) begin
          nxt_r.target_tx = want_tx;
          nxt_r.state = rms_pkg::ST_PLL;
          nxt_r.cps = `RMS_CPS_IDLE;
        end
      end
      default: nxt_r.state = rms_pkg::ST_SHDN;
    endcase

    // Power-down pin overrides everything and wipes registers
    if (pin_hi) begin
      nxt_r.state = rms_pkg::ST_SHDN;
      nxt_r.mode = `RMS_MODE_RESET;
      nxt_r.irq_st1 = 8'h00;
      nxt_r.irq_st2 = 8'h00;
      nxt_r.irq_en1 = `RMS_IRQ_EN1_RESET;
      nxt_r.irq_en2 = `RMS_IRQ_EN2_RESET;
      nxt_r.xtal_ctrl = 8'h00;
      nxt_r.cond_hi = 8'h00;
      nxt_r.cps = `RMS_CPS_SHDN;
      nxt_r.timer = 24'h000000;
    end

    nxt_r.irq_n = ~(|(nxt_r.irq_st1 & nxt_r.irq_en1) |
                    |(nxt_r.irq_st2 & nxt_r.irq_en2));
    nxt_r.pwr = power_map(nxt_r.state, nxt_r.mode);
  end

  // ==========================================================
  // Block enables per state: {lp,main,xtal,pll,cal,pa,rx,modem,wut,lbd}
  function automatic logic [9:0] power_map(
    input rms_pkg::rms_state_e st,
    input logic [7:0] md
  );
    logic on;
    logic xt;
    logic pl;
    on = (st != rms_pkg::ST_SHDN) && (st != rms_pkg::ST_POR);
    xt = md[`RMS_MC_XTON] | md[`RMS_MC_PLLON];
    pl = md[`RMS_MC_PLLON];
    power_map = 10'h000;
    if (st == rms_pkg::ST_IDLE) begin
      // Sleep/standby use low-power regulator only
      power_map[9] = ~(xt | md[`RMS_MC_LBD]);
      power_map[8] = xt | md[`RMS_MC_LBD];
      power_map[7] = xt;
      power_map[6] = pl;
      power_map[1] = md[`RMS_MC_WUT];
      power_map[0] = md[`RMS_MC_LBD];
    end else if (on) begin
      power_map[8] = 1'b1;
      power_map[7] = (st != rms_pkg::ST_REG);
      power_map[6] = (st != rms_pkg::ST_REG) && (st != rms_pkg::ST_XTAL);
      power_map[5] = (st == rms_pkg::ST_CAL);
      power_map[4] = (st == rms_pkg::ST_RAMP) || (st == rms_pkg::ST_TX);
      power_map[3] = (st == rms_pkg::ST_RXEN) || (st == rms_pkg::ST_RX);
      power_map[2] = (st == rms_pkg::ST_RX);
      power_map[1] = md[`RMS_MC_WUT];
      power_map[0] = md[`RMS_MC_LBD];
    end
  endfunction

  function automatic rms_pkg::rms_state_e rms_rms_dummy();
    rms_rms_dummy = rms_pkg::ST_SHDN;
  endfunction

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      r_ff <= '0;
      r_ff.pin_sync <= 2'h3;
      r_ff.pin_q <= 1'b1;
      r_ff.state <= rms_pkg::ST_SHDN;
      r_ff.mode <= `RMS_MODE_RESET;
      r_ff.irq_en2 <= `RMS_IRQ_EN2_RESET;
      r_ff.cps <= `RMS_CPS_SHDN;
      r_ff.irq_n <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from flip-flops
  assign AVS_READDATA = r_ff.rdata;
  assign AVS_WAITREQUEST = ~r_ff.wait_n;
  assign INTERRUPT_REQUEST_N = r_ff.irq_n;
  assign LOW_POWER_REGULATOR_EN = r_ff.pwr[9];
  assign MAIN_REGULATOR_EN = r_ff.pwr[8];
  assign XTAL_EN = r_ff.pwr[7];
  assign PLL_EN = r_ff.pwr[6];
  assign VCO_CAL_EN = r_ff.pwr[5];
  assign PA_EN = r_ff.pwr[4];
  assign RX_PATH_EN = r_ff.pwr[3];
  assign MODEM_RX_EN = r_ff.pwr[2];
  assign WAKE_TIMER_EN = r_ff.pwr[1];
  assign BATT_DETECT_EN = r_ff.pwr[0];

endmodule

/* rms_radio_mode_sequencer_props.sv */
// Port checker of the radio mode sequencer
`timescale 1ns/1ps
module rms_radio_mode_sequencer_props (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic POWER_DOWN_PIN,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic MAIN_REGULATOR_EN,
  input wire logic LOW_POWER_REGULATOR_EN,
  input wire logic XTAL_EN,
  input wire logic PLL_EN,
  input wire logic VCO_CAL_EN,
  input wire logic PA_EN,
  input wire logic RX_PATH_EN,
  input wire logic MODEM_RX_EN
);
  // ==========================================
  // Bus answer and block enable relations
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_ans;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !POWER_DOWN_PIN
      |=> !AVS_WAITREQUEST;
  endproperty
  property p_one;
    $fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST;
  endproperty
  property p_upper;
    !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000;
  endproperty
  property p_pdn;
    $rose(POWER_DOWN_PIN) |-> ##[1:5]
      !(MAIN_REGULATOR_EN || XTAL_EN || PLL_EN || PA_EN || RX_PATH_EN);
  endproperty
  property p_tx;
    PA_EN |-> PLL_EN && XTAL_EN && MAIN_REGULATOR_EN && !RX_PATH_EN;
  endproperty
  property p_rx;
    RX_PATH_EN |-> PLL_EN && XTAL_EN && MAIN_REGULATOR_EN;
  endproperty
  property p_modem;
    $rose(MODEM_RX_EN) |-> $past(RX_PATH_EN);
  endproperty
  property p_lp;
    LOW_POWER_REGULATOR_EN |-> !MAIN_REGULATOR_EN && !XTAL_EN && !PLL_EN;
  endproperty
  property p_cal;
    VCO_CAL_EN |-> PLL_EN && XTAL_EN && !PA_EN;
  endproperty
  a_ans: assert property (p_ans) else $error("no bus answer");
  a_one: assert property (p_one) else $error("long answer");
  a_upper: assert property (p_upper) else $error("upper data");
  a_pdn: assert property (p_pdn) else $error("still powered");
  a_tx: assert property (p_tx) else $error("pa order");
  a_rx: assert property (p_rx) else $error("rx order");
  a_modem: assert property (p_modem) else $error("modem early");
  a_lp: assert property (p_lp) else $error("lp regulator");
  a_cal: assert property (p_cal) else $error("cal order");
  c_tx: cover property ($rose(PA_EN));
  c_rx: cover property ($rose(MODEM_RX_EN));
  c_cal: cover property ($rose(VCO_CAL_EN));
endmodule

/* tb_radio_mode_sequencer.sv */
// Self-checking bench of the radio mode sequencer
`timescale 1ns/1ps
`include "rms_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_radio_mode_sequencer;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pdn, rd, wr, wreq, irq_n, seen;
  logic [5:0] addr;
  logic [31:0] wdata, rdata;
  logic [9:0] en, en_v;
  logic [7:0] q, d;
  int mismatches = 0;
  int n_checks = 0;
  int n;
  // Order: main, lp, xtal, pll, cal, pa, rx, modem, wut, batt
  localparam logic [9:0] RDY = 10'b1010000000;
  logic [7:0] md [5] = '{8'h00, 8'h40, 8'h20, 8'h02, 8'h01};
  logic [9:0] ev [5] = '{10'h100, 10'h102, 10'h201, 10'h2C0, RDY};
  rms_radio_mode_sequencer DUT (.CLK_SYS(clk), .RST(rst),
    .POWER_DOWN_PIN(pdn), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .INTERRUPT_REQUEST_N(irq_n),
    .MAIN_REGULATOR_EN(en[9]), .LOW_POWER_REGULATOR_EN(en[8]),
    .XTAL_EN(en[7]), .PLL_EN(en[6]), .VCO_CAL_EN(en[5]), .PA_EN(en[4]),
    .RX_PATH_EN(en[3]), .MODEM_RX_EN(en[2]), .WAKE_TIMER_EN(en[1]),
    .BATT_DETECT_EN(en[0]));
  rms_host_model host (.clk(clk), .addr(addr), .rd_en(rd), .wr_en(wr),
    .wdata(wdata), .rdata(rdata), .wait_req(wreq), .pdn(pdn));
  // ==========================================
  // Clock and helpers
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic near(input int got, input int us);
    return got >= us * `RMS_CLK_MHZ * 9 / 10 &&
           got <= us * `RMS_CLK_MHZ * 11 / 10;
  endfunction
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] v);
    host.xfer(w, a, v, q);
  endtask
  task automatic wait_en(input int b, input int lim);
    n = 0;
    seen = 1'b0;
    while (en[b] !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
      seen |= en[5];
    end
  endtask
  task automatic wait_vec(input logic [9:0] v, input int lim);
    n = 0;
    while (en !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic done(input string s);
    $display("test %s done, checks %0d", s, n_checks);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (4000000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(48777));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_vec(RDY, 1700000);
    `CHK(en, RDY)
    `CHK(irq_n, 1'b0)
    host.por_clear(q);
    `CHK(q[0], 1'b1)
    repeat (2) @(posedge clk);
    `CHK(irq_n, 1'b1)
    acc(1'b0, `RMS_ADDR_MODE_CTRL, 8'h00);
    `CHK(q, `RMS_MODE_RESET)
    acc(1'b0, 6'h3C, 8'h00);
    `CHK(q, 8'h00)
    done("por");
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, `RMS_ADDR_MODE_CTRL, md[i]);
      wait_vec(ev[i], 30000);
      `CHK(en, ev[i])
      for (int k = 0; k < 3 && i == 0; k++) begin
        d = 8'($urandom);
        acc(1'b1, `RMS_ADDR_IRQ_EN1, d);
        acc(1'b0, `RMS_ADDR_IRQ_EN1, 8'h00);
        `CHK(q, d)
      end
    end
    done("modes");
    acc(1'b1, `RMS_ADDR_MODE_CTRL, 8'h00);
    wait_vec(ev[0], 100);
    acc(1'b1, `RMS_ADDR_MODE_CTRL, 8'h08);
    wait_en(4, 200000);
    `CHK(near(n, 800), 1'b1)
    `CHK(seen, 1'b1)
    acc(1'b0, `RMS_ADDR_CHIP_COND, 8'h00);
    `CHK(q[1:0], `RMS_CPS_TX)
    acc(1'b1, `RMS_ADDR_MODE_CTRL, 8'h04);
    wait_en(2, 200000);
    `CHK(near(n, 200), 1'b1)
    acc(1'b0, `RMS_ADDR_CHIP_COND, 8'h00);
    `CHK(q[1:0], `RMS_CPS_RX)
    done("tx_rx");
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, `RMS_ADDR_MODE_CTRL, 8'h01);
      wait_vec(RDY, 30000);
      en_v = en;
      acc(1'b1, `RMS_ADDR_MODE_CTRL, i == 0 ? 8'h0F : 8'h19);
      wait_en(i == 0 ? 2 : 4, 200000);
      `CHK(near(n, 200), 1'b1)
      `CHK(en[4], i == 1)
      if (i == 1) `CHK(seen, 1'b0)
    end
    done("ready");
    host.set_pdn(1'b1);
    repeat (10) @(posedge clk);
    `CHK(en, 10'h000)
    host.set_pdn(1'b0);
    repeat (1000) @(posedge clk);
    `CHK(en[7], 1'b0)
    wait_vec(RDY, 1700000);
    acc(1'b0, `RMS_ADDR_MODE_CTRL, 8'h00);
    `CHK(q, `RMS_MODE_RESET)
    `CHK(host.tmo, 0)
    done("shutdown");
    finish_test();
  end
endmodule
bind rms_radio_mode_sequencer rms_radio_mode_sequencer_props u_props (
  .CLK_SYS(CLK_SYS), .RST(RST), .POWER_DOWN_PIN(POWER_DOWN_PIN),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .MAIN_REGULATOR_EN(MAIN_REGULATOR_EN),
  .LOW_POWER_REGULATOR_EN(LOW_POWER_REGULATOR_EN), .XTAL_EN(XTAL_EN),
  .PLL_EN(PLL_EN), .VCO_CAL_EN(VCO_CAL_EN), .PA_EN(PA_EN),
  .RX_PATH_EN(RX_PATH_EN), .MODEM_RX_EN(MODEM_RX_EN));
